// *** verilog/drc_defines.svh ***
// Constants for the run-command logic: codes, bit positions, reset values
`ifndef DRC_DEFINES_SVH
`define DRC_DEFINES_SVH
`define DRC_FN_NONE        10'h000
`define DRC_FN_HOLD        10'h006
`define DRC_FN_LINK        10'h018
`define DRC_FN_FWD         10'h062
`define DRC_FN_REV         10'h063
`define DRC_FN_COAST       10'h002
`define DRC_FN_RESET       10'h008
`define DRC_FN_EXTALM      10'h009
`define DRC_NEG_OFFSET     10'h3e8
`define DRC_WORD_FWD_BIT   0
`define DRC_WORD_REV_BIT   1
`define DRC_WORD_COAST_BIT 2
`define DRC_WORD_ARST_BIT  3
`define DRC_WORD_P13_BIT   13
`define DRC_WORD_P14_BIT   14
`define DRC_SRC_KEYPAD     2'h0
`define DRC_STOP_PRIO_A    2'h1
`define DRC_STOP_PRIO_B    2'h3
`define DRC_WORD_RESET     16'h0000
`define DRC_TIMER_RESET    32'h0000_0000
`endif

// *** verilog/drc_pkg.sv ***
// Types shared by the run-command logic
package drc_pkg;
	// Keypad key pulses
	typedef struct packed {
		logic run_key;
		logic stop_key;
		logic jog_active;
	} drc_keys_t;
	// Decoded internal commands
	typedef struct packed {
		logic forward_run_cmd;
		logic backward_run_cmd;
		logic hold;
		logic link;
		logic coast;
		logic alarm_reset;
		logic ext_alarm;
	} drc_cmds_t;
	// Latched run state
	typedef enum logic [1:0] {
		DRC_IDLE = 2'b00,
		DRC_RUN  = 2'b01,
		DRC_DONE = 2'b11
	} drc_state_t;
endpackage : drc_pkg

// *** verilog/drc_run_command.sv ***
// Run-command generator and digital input decoder of the inverter
//
// Operation
// [R1] Keypad run latches on, stop clears, except jogging
// [R2] Hold terminal latches forward or backward request
// [R3] Without hold assignment, follow direction levels directly
// [R4] Source zero: keypad run AND terminal direction
// [R5] Link word bits 0,1 run; 13,14 programmable
// [R6] Terminal function codes choose which word bit
// [R7] Link command is OR of bits 13,14
// [R8] Both directions on forces internal runs off
// [R9] Stop key priority 1 or 3 forces off
// [R10] Timer expiry clears run and keypad hold
// [R11] Below start or stop frequency: runs off
// [R12] Five inputs mapped by code; +1000 inverts
// [R13] General commands: negative logic, link replaces terminal
// [R14] Terminal-only commands never overridden by link
// [R15] Direction decoder rejects negative logic, ignores link
// [R16] OR-type commands: link or terminal asserts
// [R17] Link-ignoring commands use terminals only
// [R18] Link command may come from a general input
// [R19] Bits 13,14 on same command are ORed
// [R20] One clock; reset clears latches
`timescale 1ns/100ps
`include "drc_defines.svh"
module drc_run_command
	import drc_pkg::*;
#(
	parameter int FREQ_W = 16,
	parameter int TIME_W = 32
) (
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic              clk_en,
	input  wire logic [4:0]        terminal_pins,
	input  wire logic [9:0]        input_function [5],
	input  wire logic [9:0]        forward_terminal_function,
	input  wire logic [9:0]        backward_terminal_function,
	input  wire drc_keys_t         keys,
	input  wire logic [1:0]        run_source_select,
	input  wire logic [1:0]        stop_key_priority_select,
	input  wire logic              link_word_we,
	input  wire logic [15:0]       link_word_wdata,
	input  wire logic              timer_enable,
	input  wire logic [TIME_W-1:0] timer_preset,
	input  wire logic [FREQ_W-1:0] reference_frequency,
	input  wire logic [FREQ_W-1:0] start_frequency,
	input  wire logic [FREQ_W-1:0] stop_frequency,
	output logic [15:0]            link_operation_word,
	output logic                   internal_fwd,
	output logic                   internal_rev,
	output logic                   link_operation_cmd,
	output logic                   coast_cmd,
	output logic                   alarm_reset_cmd,
	output logic                   ext_alarm_cmd,
	output logic                   timer_expired
);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchroniser: first stage read only by second
	logic [4:0] pin_s1_q, pin_s2_q, pin_s1_d, pin_s2_d;
	always_comb begin
		pin_s1_d = pin_s1_q;
		pin_s2_d = pin_s2_q;
		if (clk_en) begin
			pin_s1_d = terminal_pins;
			pin_s2_d = pin_s1_q;
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			pin_s1_q <= 5'h00;
			pin_s2_q <= 5'h00;
		end else begin
			pin_s1_q <= pin_s1_d;
			pin_s2_q <= pin_s2_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Link operation word register
	logic [15:0] word_q, word_d;
	always_comb begin
		word_d = word_q;
		if (clk_en && link_word_we)
			word_d = link_word_wdata;
	end

	////////////////////////////////////////////////////////////////////////////
	// Per-input decode; codes 1000 and up invert the pin
	logic [9:0] base_code [5];
	logic [4:0] neg_sel;
	logic [4:0] act;
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_in
			assign neg_sel[gi]   = (input_function[gi] >= `DRC_NEG_OFFSET); // [R12]
			assign base_code[gi] = neg_sel[gi] ? input_function[gi] - `DRC_NEG_OFFSET
			                                   : input_function[gi];
			// Direction codes never take inversion, for safety
			assign act[gi] = (neg_sel[gi] && (base_code[gi] == `DRC_FN_FWD || base_code[gi] == `DRC_FN_REV))
			                 ? 1'b0 : pin_s2_q[gi] ^ neg_sel[gi]; // [R12] [R15]
		end
	endgenerate

	// Command gathering: OR of all inputs carrying each code
	function automatic logic any_code(input logic [9:0] code);
		logic r;
		r = 1'b0;
		for (int i = 0; i < 5; i++)
			r = r | (act[i] && base_code[i] == code);
		return r;
	endfunction

	logic hold_assigned;
	always_comb begin
		hold_assigned = 1'b0;
		for (int i = 0; i < 5; i++)
			hold_assigned = hold_assigned | (base_code[i] == `DRC_FN_HOLD);
	end

	drc_cmds_t tc;
	logic      p_fwd, p_rev, le_word, lnk;
	always_comb begin
		tc.forward_run_cmd         = any_code(`DRC_FN_FWD);    // [R15] terminals only
		tc.backward_run_cmd         = any_code(`DRC_FN_REV);    // [R15]
		tc.hold        = any_code(`DRC_FN_HOLD);
		tc.link        = any_code(`DRC_FN_LINK);   // [R18]
		tc.coast       = any_code(`DRC_FN_COAST);
		tc.alarm_reset = any_code(`DRC_FN_RESET);
		tc.ext_alarm   = any_code(`DRC_FN_EXTALM);
		// Programmable word bits act as the direction terminals
		p_fwd   = (word_q[`DRC_WORD_P13_BIT] && forward_terminal_function == `DRC_FN_FWD)
		        | (word_q[`DRC_WORD_P14_BIT] && backward_terminal_function == `DRC_FN_FWD); // [R6] [R19]
		p_rev   = (word_q[`DRC_WORD_P13_BIT] && forward_terminal_function == `DRC_FN_REV)
		        | (word_q[`DRC_WORD_P14_BIT] && backward_terminal_function == `DRC_FN_REV); // [R6] [R19]
		le_word = word_q[`DRC_WORD_P13_BIT] | word_q[`DRC_WORD_P14_BIT]; // [R7]
		lnk     = le_word | tc.link; // [R18]
	end

	////////////////////////////////////////////////////////////////////////////
	// Run generator: source select, latches, blanking
	logic fwd_req, rev_req, hold_en;
	logic key_run_q, key_run_d, fwd_lat_q, fwd_lat_d, rev_lat_q, rev_lat_d;
	logic fwd_q, fwd_d, rev_q, rev_d;
	logic [TIME_W-1:0] tmr_q, tmr_d;
	drc_state_t st_q, st_d;
	logic blank, stop_prio, expire;
	always_comb begin
		// Link replaces terminal direction when active
		fwd_req   = lnk ? (word_q[`DRC_WORD_FWD_BIT] | p_fwd) : tc.forward_run_cmd; // [R5] [R13]
		rev_req   = lnk ? (word_q[`DRC_WORD_REV_BIT] | p_rev) : tc.backward_run_cmd; // [R5] [R13]
		hold_en   = hold_assigned;
		stop_prio = keys.stop_key && (stop_key_priority_select == `DRC_STOP_PRIO_A
		                           || stop_key_priority_select == `DRC_STOP_PRIO_B); // [R9]
		expire    = timer_enable && st_q == DRC_RUN && tmr_q >= timer_preset;
		key_run_d = key_run_q;
		if (keys.run_key)
			key_run_d = 1'b1; // [R1]
		else if (keys.stop_key && !keys.jog_active)
			key_run_d = 1'b0; // [R1]
		if (expire)
			key_run_d = 1'b0; // [R10]
		// Three-wire latch held until hold drops or the timer expires
		fwd_lat_d = hold_en && tc.hold && (fwd_lat_q | fwd_req); // [R2]
		rev_lat_d = hold_en && tc.hold && (rev_lat_q | rev_req); // [R2]
		fwd_d = hold_en ? fwd_lat_d : fwd_req; // [R3]
		rev_d = hold_en ? rev_lat_d : rev_req; // [R3]
		if (run_source_select == `DRC_SRC_KEYPAD && !lnk) begin
			fwd_d = key_run_d && fwd_d; // [R4]
			rev_d = key_run_d && rev_d; // [R4]
		end
		blank = (fwd_d && rev_d) // [R8]
		      || stop_prio // [R9]
		      || expire || st_q == DRC_DONE // [R10]
		      || reference_frequency < start_frequency
		      || reference_frequency < stop_frequency; // [R11]
		if (blank) begin
			fwd_d = 1'b0;
			rev_d = 1'b0;
		end
		if (expire) begin
			fwd_lat_d = 1'b0; // [R10]
			rev_lat_d = 1'b0;
		end
		// Timer: starts on any run request, done until requests drop
		st_d  = st_q;
		tmr_d = tmr_q;
		case (st_q)
			DRC_IDLE: begin
				tmr_d = TIME_W'(`DRC_TIMER_RESET);
				if (timer_enable && (fwd_req || rev_req || key_run_q))
					st_d = DRC_RUN; // [R10]
			end
			DRC_RUN: begin
				tmr_d = tmr_q + 1'b1;
				if (!timer_enable)
					st_d = DRC_IDLE;
				else if (expire)
					st_d = DRC_DONE;
			end
			DRC_DONE: begin
				if (!(fwd_req || rev_req || keys.run_key))
					st_d = DRC_IDLE;
			end
			default: st_d = DRC_IDLE;
		endcase
		if (!clk_en) begin
			key_run_d = key_run_q;
			fwd_lat_d = fwd_lat_q;
			rev_lat_d = rev_lat_q;
			fwd_d     = fwd_q;
			rev_d     = rev_q;
			st_d      = st_q;
			tmr_d     = tmr_q;
		end
	end

	// Output commands: general ones switched by link, alarm reset ORed with the word, external alarm terminal-only
	logic le_q, le_d, coast_q, coast_d, arst_q, arst_d, ealm_q, ealm_d;
	logic texp_q, texp_d;
	always_comb begin
		le_d    = clk_en ? lnk : le_q;
		coast_d = clk_en ? (lnk ? word_q[`DRC_WORD_COAST_BIT] : tc.coast) : coast_q; // [R13]
		arst_d  = clk_en ? (word_q[`DRC_WORD_ARST_BIT] | tc.alarm_reset) : arst_q; // [R16]
		ealm_d  = clk_en ? tc.ext_alarm : ealm_q; // [R14] [R17]
		texp_d  = (st_d == DRC_DONE); // Registered so the flag leaves a flop; st_d already frozen
	end

	////////////////////////////////////////////////////////////////////////////
	// State registers; reset clears every latch
	always_ff @(posedge clk) begin
		if (reset) begin // [R20]
			word_q    <= `DRC_WORD_RESET;
			key_run_q <= 1'b0;
			fwd_lat_q <= 1'b0;
			rev_lat_q <= 1'b0;
			fwd_q     <= 1'b0;
			rev_q     <= 1'b0;
			st_q      <= DRC_IDLE;
			tmr_q     <= TIME_W'(`DRC_TIMER_RESET);
			le_q      <= 1'b0;
			coast_q   <= 1'b0;
			arst_q    <= 1'b0;
			ealm_q    <= 1'b0;
			texp_q    <= 1'b0;
		end else begin
			word_q    <= word_d;
			key_run_q <= key_run_d;
			fwd_lat_q <= fwd_lat_d;
			rev_lat_q <= rev_lat_d;
			fwd_q     <= fwd_d;
			rev_q     <= rev_d;
			st_q      <= st_d;
			tmr_q     <= tmr_d;
			le_q      <= le_d;
			coast_q   <= coast_d;
			arst_q    <= arst_d;
			ealm_q    <= ealm_d;
			texp_q    <= texp_d;
		end
	end

	assign link_operation_word = word_q;
	assign internal_fwd        = fwd_q;
	assign internal_rev        = rev_q;
	assign link_operation_cmd  = le_q;
	assign coast_cmd           = coast_q;
	assign alarm_reset_cmd     = arst_q;
	assign ext_alarm_cmd       = ealm_q;
	assign timer_expired       = texp_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	a_never_both: assert property (@(posedge clk) disable iff (reset) !(fwd_q && rev_q)) // [R8]
		else $error("both internal runs on");
	a_stop_blank: assert property (@(posedge clk) disable iff (reset)
		(clk_en && stop_prio) |=> !fwd_q && !rev_q) // [R9]
		else $error("stop key did not blank runs");
	a_freq_gate: assert property (@(posedge clk) disable iff (reset)
		(clk_en && reference_frequency < start_frequency) |=> !fwd_q && !rev_q) // [R11]
		else $error("run below start frequency");
	a_link_or: assert property (@(posedge clk) disable iff (reset)
		(clk_en && (word_q[`DRC_WORD_P13_BIT] || word_q[`DRC_WORD_P14_BIT])) |=> le_q) // [R7]
		else $error("link command missing");
	a_key_latch: assert property (@(posedge clk) disable iff (reset)
		(clk_en && keys.run_key) |=> key_run_q) // [R1]
		else $error("run key not latched");
	a_key_clear: assert property (@(posedge clk) disable iff (reset)
		(clk_en && keys.stop_key && !keys.run_key && !keys.jog_active) |=> !key_run_q) // [R1]
		else $error("stop key did not clear");
	a_timer_cut: assert property (@(posedge clk) disable iff (reset)
		(clk_en && expire) |=> !fwd_q && !rev_q && !key_run_q && timer_expired) // [R10]
		else $error("timer did not cut run");
	a_ext_term: assert property (@(posedge clk) disable iff (reset)
		(clk_en && !tc.ext_alarm) |=> !ealm_q) // [R14]
		else $error("terminal-only command from link");
	a_two_wire: assert property (@(posedge clk) disable iff (reset)
		(clk_en && !hold_assigned && !blank && run_source_select != `DRC_SRC_KEYPAD && !lnk && tc.forward_run_cmd)
		|=> fwd_q) // [R3]
		else $error("two-wire forward not followed");
	c_fwd_run:   cover property (@(posedge clk) fwd_q);
	c_rev_run:   cover property (@(posedge clk) rev_q);
	c_timer_hit: cover property (@(posedge clk) expire);
	c_link_mode: cover property (@(posedge clk) le_q && fwd_q);
endmodule : drc_run_command

// *** dv/drc_field_model.sv ***
// Terminal block model: contacts follow requests
`timescale 1ns/100ps
module drc_field_model (
	input  wire logic       clk,
	input  wire logic [4:0] pin_req,
	output logic      [4:0] terminal_pins
);
	////////////////////////////////////////
	// Contacts close a cycle late, like a relay, so sync timing is exercised
	always_ff @(posedge clk) begin
		terminal_pins <= pin_req;
	end
endmodule : drc_field_model

// *** dv/drc_run_command_bench.sv ***
// Bench for the run-command logic: pin, key and link word sequences
`timescale 1ns/100ps
`include "drc_defines.svh"
module drc_run_command_bench
	import drc_pkg::*;
;
	logic        clk, reset, we, ten, en;
	logic        ixf, irv, lcmd, coast, arst, ealm, texp;
	logic [4:0]  pin_req, pins;
	logic [9:0]  fn [5];
	logic [9:0]  bfn;
	drc_keys_t   keys;
	logic [1:0]  src, prio;
	logic [15:0] wd, word, rf, pf;
	logic [31:0] preset;
	logic [6:0]  st;
	int          errors, n_tests, cyc;
	assign st = {texp, ealm, arst, coast, lcmd, irv, ixf};
	////////////////////////////////////////
	// Far side and device
	drc_field_model fm (.clk(clk), .pin_req(pin_req), .terminal_pins(pins));
	drc_run_command dut (.clk(clk), .reset(reset), .clk_en(en), .terminal_pins(pins),
		.input_function(fn), .forward_terminal_function(`DRC_FN_FWD),
		.backward_terminal_function(bfn), .keys(keys), .run_source_select(src),
		.stop_key_priority_select(prio), .link_word_we(we), .link_word_wdata(wd),
		.timer_enable(ten), .timer_preset(preset), .reference_frequency(rf),
		.start_frequency(16'h0010), .stop_frequency(pf), .link_operation_word(word),
		.internal_fwd(ixf), .internal_rev(irv), .link_operation_cmd(lcmd), .coast_cmd(coast),
		.alarm_reset_cmd(arst), .ext_alarm_cmd(ealm), .timer_expired(texp));
	////////////////////////////////////////
	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			final_report();
		end
	end
	////////////////////////////////////////
	// Shared tasks
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Status word compare after pins have synced through
	task automatic pin_chk(input logic [4:0] p, input logic [6:0] e);
		pin_req = p;
		step(6);
		chk({9'h000, st}, {9'h000, e});
	endtask : pin_chk
	// One-cycle key pulse; registered answer checked while it stands, then an edge passes idle
	task automatic key(input drc_keys_t k, input logic [6:0] e);
		keys = k;
		step(1);
		chk({9'h000, st}, {9'h000, e});
		keys = '0;
		step(1);
	endtask : key
	task automatic wr(input logic [15:0] d);
		wd = d;
		we = 1'b1;
		step(1);
		we = 1'b0;
		step(2);
		chk(word, d);
	endtask : wr
	task automatic final_report;
		if (errors == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : final_report
	////////////////////////////////////////
	// Main sequence
	initial begin
		reset = 1'b1; we = 1'b0; ten = 1'b0; wd = 16'h0000; keys = '0;
		pin_req = 5'h00; src = 2'h1; prio = 2'h0; rf = 16'h0100; preset = 32'h0000_000a;
		pf = 16'h0010; bfn = `DRC_FN_REV; en = 1'b1;
		fn = '{`DRC_FN_NONE, `DRC_FN_NONE, `DRC_FN_NONE, `DRC_FN_FWD, `DRC_FN_REV};
		step(20);
		chk({9'h000, st}, 16'h0000);
		reset = 1'b0;
		pin_chk(5'h08, 7'h01);
		// Enable low freezes all state: the pin drop is ignored until re-enabled
		en = 1'b0;
		pin_chk(5'h00, 7'h01);
		en = 1'b1;
		pin_chk(5'h00, 7'h00);
		pin_chk(5'h18, 7'h00);
		rf = 16'h0008;
		pin_chk(5'h08, 7'h00);
		rf = 16'h0100;
		pf = 16'h0200;
		pin_chk(5'h08, 7'h00);
		pf = 16'h0010;
		prio = 2'h1;
		pin_chk(5'h08, 7'h01);
		key('{1'b0, 1'b1, 1'b0}, 7'h00);
		prio = 2'h0;
		fn[0] = `DRC_FN_HOLD;
		pin_chk(5'h09, 7'h01);
		pin_chk(5'h01, 7'h01);
		pin_chk(5'h00, 7'h00);
		fn[0] = `DRC_FN_NONE;
		// Keypad source: run key gated by terminal direction
		src = 2'h0;
		pin_chk(5'h08, 7'h00);
		key('{1'b1, 1'b0, 1'b0}, 7'h01);
		key('{1'b0, 1'b1, 1'b1}, 7'h01);
		key('{1'b0, 1'b1, 1'b0}, 7'h00);
		// Mid-run reset must drop the keypad latch
		key('{1'b1, 1'b0, 1'b0}, 7'h01);
		reset = 1'b1;
		step(2);
		reset = 1'b0;
		pin_chk(5'h08, 7'h00);
		src = 2'h1;
		fn[1] = `DRC_FN_COAST;
		pin_chk(5'h02, 7'h08);
		wr(16'h2000);
		chk({9'h000, st}, 16'h0005);
		wr(16'h4008);
		chk({9'h000, st}, 16'h0016);
		// Bit 14 set up as forward drives forward alone
		bfn = `DRC_FN_FWD;
		wr(16'h4000);
		chk({9'h000, st}, 16'h0005);
		bfn = `DRC_FN_REV;
		wr(16'h0000);
		// Link command from a general input switches coast to the word
		fn[0] = `DRC_FN_LINK;
		pin_chk(5'h03, 7'h04);
		fn[0] = `DRC_FN_NONE;
		pin_chk(5'h00, 7'h00);
		fn[1] = `DRC_FN_NONE;
		fn[2] = `DRC_FN_EXTALM + `DRC_NEG_OFFSET;
		pin_chk(5'h00, 7'h20);
		pin_chk(5'h04, 7'h00);
		fn[2] = `DRC_FN_NONE;
		fn[3] = `DRC_FN_FWD + `DRC_NEG_OFFSET;
		pin_chk(5'h00, 7'h00);
		fn[3] = `DRC_FN_FWD;
		// Timer cuts the run once the preset has elapsed
		ten = 1'b1;
		pin_req = 5'h08;
		step(20);
		chk({9'h000, st}, 16'h0040);
		pin_chk(5'h00, 7'h00);
		ten = 1'b0;
		final_report();
	end
endmodule : drc_run_command_bench
